// ==== src/dmo_operand_unit.v ====
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "dmo_consts.vh"

module dmo_operand_unit #(
   parameter MEM_AW = 12
) (
   input wire clk_i,
   input wire rst_i,
   input wire op_valid_i,
   input wire op_file_i,
   input wire op_we_i,
   input wire [7:0] op_f_i,
   input wire op_a_i,
   input wire [7:0] op_wdata_i,
   input wire [7:0] wreg_i,
   output reg op_done_o,
   output reg [7:0] op_rdata_o,
   output reg [11:0] op_ea_o,
   output reg op_lit_o,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o
);

   reg [7:0] mem_q [0:(1 << MEM_AW) - 1];
   reg [11:0] ptr_q [0:2];
   reg [11:0] ptr_d [0:2];
   reg [3:0] bsr_q;
   reg [3:0] bsr_d;
   reg ctrl_extended_set_enable_bit_q;
   reg [14:0] last_q;

   wire [11:0] d_addr;
   wire d_lit;

   reg is_virt;
   reg [1:0] vk;
   reg [2:0] vsub;
   reg [11:0] vptr;
   reg [11:0] ea;
   reg nested;
   reg t_pbyte;
   reg [1:0] t_pk;
   reg t_phi;
   reg t_bsr;
   reg [7:0] rd_val;
   reg step_en;
   reg [11:0] step_val;
   reg wr_pbyte;
   reg wr_bsr;
   reg wr_mem;
   reg [5:0] vinf;
   reg [3:0] pinf;

   wire op_go;
   wire wb_req;

   assign op_go = op_valid_i && op_file_i;
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   function [11:0] vbase;
      input [1:0] k;
      begin
         case (k)
            2'h0: vbase = `DMO_IND0_BASE;
            2'h1: vbase = `DMO_IND1_BASE;
            default: vbase = `DMO_IND2_BASE;
         endcase
      end
   endfunction

   // {hit, pointer, kind} for an address inside a virtual register block
   function [5:0] vdec;
      input [11:0] ad;
      reg [11:0] df;
      integer k;
      begin
         vdec = 6'h00;
         df = 12'h000;
         for (k = 0; k < 3; k = k + 1)
         begin
            df = vbase(k[1:0]) - ad;
            if (ad <= vbase(k[1:0]) && df < `DMO_VREG_SPAN)
            begin
               vdec = {1'b1, k[1:0], df[2:0]};
            end
         end
      end
   endfunction

   // {hit, pointer, high byte} for an address on a pointer byte
   function [3:0] pdec;
      input [11:0] ad;
      integer k;
      begin
         pdec = 4'h0;
         for (k = 0; k < 3; k = k + 1)
         begin
            if (ad == vbase(k[1:0]) - `DMO_PTRL_OFS)
            begin
               pdec = {1'b1, k[1:0], 1'b0};
            end
            if (ad == vbase(k[1:0]) - `DMO_PTRH_OFS)
            begin
               pdec = {1'b1, k[1:0], 1'b1};
            end
         end
      end
   endfunction

   dmo_addr_gen u_addr_gen (
      .file_i(op_f_i),
      .access_sel_i(op_a_i),
      .extended_set_enable_bit_i(ctrl_extended_set_enable_bit_q),
      .bsr_i(bsr_q),
      .ptr2_i(ptr_q[2]),
      .addr_o(d_addr),
      .lit_o(d_lit)
   );

   // resolve virtual register access into final target
   always @*
   begin
      vinf = vdec(d_addr);
      is_virt = vinf[5];
      vk = vinf[4:3];
      vsub = vinf[2:0];
      vptr = ptr_q[vk];
      case (vsub)
         `DMO_SUB_PREINC: ea = vptr + 12'h001;
         `DMO_SUB_INDIRECT_PLUS_WORKING_OFFSET: ea = vptr + {{4{wreg_i[7]}}, wreg_i};
         default: ea = vptr;
      endcase
      if (!is_virt)
      begin
         ea = d_addr;
      end
      vinf = vdec(ea);
      nested = is_virt && vinf[5];
      pinf = pdec(ea);
      t_pbyte = pinf[3];
      t_pk = pinf[2:1];
      t_phi = pinf[0];
      t_bsr = (ea == `DMO_BSR_ADDR);
   end

   // read value and write steering
   always @*
   begin
      if (nested)
      begin
         rd_val = 8'h00;
      end
      else if (t_pbyte)
      begin
         rd_val = t_phi ? {4'h0, ptr_q[t_pk][11:8]} : ptr_q[t_pk][7:0];
      end
      else if (t_bsr)
      begin
         rd_val = {4'h0, bsr_q};
      end
      else
      begin
         rd_val = mem_q[ea[MEM_AW-1:0]];
      end
      // nested writes are dropped entirely
      wr_pbyte = op_go && op_we_i && !nested && t_pbyte;
      wr_bsr = op_go && op_we_i && !nested && t_bsr;
      wr_mem = op_go && op_we_i && !nested && !t_pbyte && !t_bsr;
      // no pointer step when a write lands on a pointer or is a no-op
      step_en = op_go && is_virt && !(op_we_i && (nested || t_pbyte));
      case (vsub)
         `DMO_SUB_POSTINC: step_val = vptr + 12'h001;
         `DMO_SUB_POSTDEC: step_val = vptr - 12'h001;
         `DMO_SUB_PREINC: step_val = vptr + 12'h001;
         default: step_val = vptr;
      endcase
      bsr_d = wr_bsr ? op_wdata_i[3:0] : bsr_q;
   end

   genvar j;
   generate
      for (j = 0; j < 3; j = j + 1)
      begin : g_ptr
         always @*
         begin
            ptr_d[j] = ptr_q[j];
            if (wr_pbyte && t_pk == j)
            begin
               // value stored as written, no step applied
               if (t_phi)
               begin
                  ptr_d[j] = {op_wdata_i[3:0], ptr_q[j][7:0]};
               end
               else
               begin
                  ptr_d[j] = {ptr_q[j][11:8], op_wdata_i};
               end
            end
            else if (step_en && vk == j)
            begin
               ptr_d[j] = step_val;
            end
         end

         always @(posedge clk_i)
         begin
            if (rst_i)
            begin
               ptr_q[j] <= `DMO_PTR_RESET;
            end
            else
            begin
               ptr_q[j] <= ptr_d[j];
            end
         end
      end
   endgenerate

   always @(posedge clk_i)
   begin
      if (wr_mem)
      begin
         mem_q[ea[MEM_AW-1:0]] <= op_wdata_i;
      end
   end

   // operand answer, one cycle after the request
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bsr_q <= `DMO_BSR_RESET;
         op_done_o <= 1'b0;
         op_rdata_o <= 8'h00;
         op_ea_o <= 12'h000;
         op_lit_o <= 1'b0;
         last_q <= 15'h0000;
      end
      else
      begin
         bsr_q <= bsr_d;
         op_done_o <= op_valid_i;
         if (op_go)
         begin
            op_rdata_o <= op_we_i ? 8'h00 : rd_val;
            op_ea_o <= ea;
            op_lit_o <= d_lit;
            last_q <= {is_virt, nested, d_lit, ea};
         end
         else if (op_valid_i)
         begin
            // inherent or literal operand: no address, no state change
            op_rdata_o <= 8'h00;
            op_ea_o <= 12'h000;
            op_lit_o <= 1'b0;
         end
      end
   end

   // wishbone classic slave, ack one cycle after strobe
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl_extended_set_enable_bit_q <= `DMO_CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_req && wb_we_i && wb_adr_i == `DMO_REG_CTRL && wb_sel_i[0])
         begin
            ctrl_extended_set_enable_bit_q <= wb_dat_i[`DMO_CTRL_EXTENDED_SET_ENABLE_BIT_BIT];
         end
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               `DMO_REG_CTRL: wb_dat_o <= {31'h00000000, ctrl_extended_set_enable_bit_q};
               `DMO_REG_LAST: wb_dat_o <= {17'h00000, last_q};
               `DMO_REG_PTR0: wb_dat_o <= {20'h00000, ptr_q[0]};
               `DMO_REG_PTR1: wb_dat_o <= {20'h00000, ptr_q[1]};
               `DMO_REG_PTR2: wb_dat_o <= {20'h00000, ptr_q[2]};
               `DMO_REG_BSR: wb_dat_o <= {28'h0000000, bsr_q};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
         else
         begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

endmodule

// ==== src/dmo_consts.vh ====
`ifndef DMO_CONSTS_VH
`define DMO_CONSTS_VH

// base (plain port) of each pointer's block of five virtual registers
`define DMO_IND0_BASE 12'hFEF
`define DMO_IND1_BASE 12'hFE7
`define DMO_IND2_BASE 12'hFDF
`define DMO_VREG_SPAN 12'h005

// pointer byte positions below the plain port of the same pointer
`define DMO_PTRL_OFS 12'h006
`define DMO_PTRH_OFS 12'h005

`define DMO_BSR_ADDR 12'hFE0

// access bank split and pages
`define DMO_ACCESS_SPLIT 8'h60
`define DMO_ACCESS_LOW_PAGE 4'h0
`define DMO_ACCESS_HIGH_PAGE 4'hF

// virtual register kinds, by distance below the plain port
`define DMO_SUB_PLAIN 3'h0
`define DMO_SUB_POSTINC 3'h1
`define DMO_SUB_POSTDEC 3'h2
`define DMO_SUB_PREINC 3'h3
`define DMO_SUB_INDIRECT_PLUS_WORKING_OFFSET 3'h4

// wishbone register byte offsets
`define DMO_REG_CTRL 8'h00
`define DMO_REG_LAST 8'h04
`define DMO_REG_PTR0 8'h08
`define DMO_REG_PTR1 8'h0C
`define DMO_REG_PTR2 8'h10
`define DMO_REG_BSR 8'h14

// control and status fields
`define DMO_CTRL_EXTENDED_SET_ENABLE_BIT_BIT 0
`define DMO_CTRL_RESET 1'h0
`define DMO_LAST_LIT_BIT 12
`define DMO_LAST_NEST_BIT 13
`define DMO_LAST_VIRT_BIT 14
`define DMO_PTR_RESET 12'h000
`define DMO_BSR_RESET 4'h0

`endif

// ==== src/dmo_addr_gen.v ====
`timescale 1ns/1ps
`include "dmo_consts.vh"

module dmo_addr_gen (
   input wire [7:0] file_i,
   input wire access_sel_i,
   input wire extended_set_enable_bit_i,
   input wire [3:0] bsr_i,
   input wire [11:0] ptr2_i,
   output reg [11:0] addr_o,
   output reg lit_o
);

   always @*
   begin
      // literal offset only with extended set, access bank forced, file below split
      lit_o = extended_set_enable_bit_i && !access_sel_i && (file_i < `DMO_ACCESS_SPLIT);
      if (lit_o)
      begin
         // offset from third pointer, bank select ignored
         addr_o = ptr2_i + {4'h0, file_i};
      end
      else if (access_sel_i)
      begin
         addr_o = {bsr_i, file_i};
      end
      else if (file_i < `DMO_ACCESS_SPLIT)
      begin
         addr_o = {`DMO_ACCESS_LOW_PAGE, file_i};
      end
      else
      begin
         addr_o = {`DMO_ACCESS_HIGH_PAGE, file_i};
      end
   end

endmodule

// ==== verif/dmo_core_model.sv ====
`timescale 1ns/1ps
module dmo_core_model (
   input wire clk_i,
   input wire req_i,
   input wire file_i,
   input wire we_i,
   input wire [7:0] f_i,
   input wire a_i,
   input wire [7:0] wd_i,
   output reg op_valid_o = 1'b0,
   output reg op_file_o,
   output reg op_we_o,
   output reg [7:0] op_f_o,
   output reg op_a_o,
   output reg [7:0] op_wdata_o
);
   // one-cycle issue; fields churn while idle so stale values never look valid
   always @(posedge clk_i)
   begin
      op_valid_o <= req_i;
      op_file_o <= req_i ? file_i : ~op_file_o;
      op_we_o <= req_i ? we_i : ~op_we_o;
      op_f_o <= req_i ? f_i : ~op_f_o;
      op_a_o <= req_i ? a_i : ~op_a_o;
      op_wdata_o <= req_i ? wd_i : ~op_wdata_o;
   end
endmodule

// ==== verif/dmo_operand_monitor.sv ====
`timescale 1ns/1ps
module dmo_operand_monitor #(
   parameter MEM_AW = 12
) (
   input wire clk_i,
   input wire rst_i,
   input wire op_valid_i,
   input wire op_file_i,
   input wire [7:0] op_f_i,
   input wire op_a_i,
   input wire op_done_o,
   input wire [11:0] op_ea_o,
   input wire op_lit_o,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire req = op_valid_i && op_file_i;
   done_follows_a: assert property (op_valid_i |=> op_done_o) else $error("done missing");
   done_alone_a: assert property (!op_valid_i |=> !op_done_o) else $error("done without request");
   plain_op_a: assert property (op_valid_i && !op_file_i |=> op_ea_o == 12'h000 && !op_lit_o)
      else $error("inherent op altered");
   bank_direct_a: assert property (req && op_a_i |=> !op_lit_o) else $error("lit with a set");
   high_file_a: assert property (req && op_f_i >= 8'h60 |=> !op_lit_o) else $error("lit high f");
   upper_map_a: assert property (req && !op_a_i && op_f_i inside {[8'h60:8'hCF]}
      |=> op_ea_o == {4'hF, $past(op_f_i)}) else $error("upper access map");
   low_map_a: assert property (req && !op_a_i && op_f_i < 8'h60
      |=> op_lit_o || op_ea_o == {4'h0, $past(op_f_i)}) else $error("lower access map");
   lit_cause_a: assert property (op_done_o && op_lit_o |-> $past(req && !op_a_i && op_f_i <= 8'h5F))
      else $error("lit without cause");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   cover property (op_done_o && op_lit_o);
   cover property (req && op_a_i);
   cover property (req && op_f_i >= 8'hD9);
endmodule
bind dmo_operand_unit dmo_operand_monitor #(.MEM_AW(MEM_AW)) dmo_operand_monitor_i (.clk_i(clk_i),
   .rst_i(rst_i), .op_valid_i(op_valid_i), .op_file_i(op_file_i), .op_f_i(op_f_i), .op_a_i(op_a_i),
   .op_done_o(op_done_o), .op_ea_o(op_ea_o), .op_lit_o(op_lit_o), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ==== verif/dmo_operand_unit_tb.sv ====
`timescale 1ns/1ps
module dmo_operand_unit_tb;
   logic clk_i = 0, rst_i = 1, rq = 0, fl = 0, we = 0, aa = 0, cyc = 0, stb = 0, wwe = 0;
   logic [7:0] fv = 0, wd = 0, wr = 0, adr = 0, f, d;
   logic [31:0] wdt = 0, q;
   wire ov, of, ow, oa, done, lit, ack;
   wire [7:0] off, owd, rd;
   wire [11:0] ea;
   wire [31:0] wq;
   int bad_count = 0, checks = 0, r;
   dmo_core_model dmo_core_model_i (.clk_i(clk_i), .req_i(rq), .file_i(fl), .we_i(we), .f_i(fv), .a_i(aa),
      .wd_i(wd), .op_valid_o(ov), .op_file_o(of), .op_we_o(ow), .op_f_o(off), .op_a_o(oa), .op_wdata_o(owd));
   dmo_operand_unit dmo_operand_unit_i (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(ov), .op_file_i(of),
      .op_we_i(ow), .op_f_i(off), .op_a_i(oa), .op_wdata_i(owd), .wreg_i(wr), .op_done_o(done),
      .op_rdata_o(rd), .op_ea_o(ea), .op_lit_o(lit), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdt), .wb_dat_o(wq), .wb_ack_o(ack));
   initial
      forever #12.5 clk_i = ~clk_i;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [11:0] exp_ea(input logic x, input logic a1, input logic [7:0] fa,
      input logic [3:0] b, input logic [11:0] p2);
      if (a1)
         return {b, fa};
      if (x && fa <= 8'h5F)
         return p2 + fa;
      return {(fa < 8'h60) ? 4'h0 : 4'hF, fa};
   endfunction
   task automatic op(input logic f1, input logic w1, input logic [7:0] fa, input logic a1, input logic [7:0] dv);
      int n;
      @(posedge clk_i);
      rq <= 1;
      fl <= f1;
      we <= w1;
      fv <= fa;
      aa <= a1;
      wd <= dv;
      @(posedge clk_i);
      rq <= 0;
      n = 0;
      while (done !== 1'b1 && n < 8)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n == 8)
         bad_count++;
   endtask
   task automatic wb(input logic w1, input logic [7:0] ad, input logic [31:0] dv);
      int n;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      wwe <= w1;
      adr <= ad;
      wdt <= dv;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 8);
      if (n == 8)
         bad_count++;
      q = wq;
      cyc <= 0;
      stb <= 0;
   endtask
   initial
   begin
      #100000;
      bad_count++;
      finish_test;
   end
   initial
   begin
      r = $urandom(32'hAD044493);
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      wb(0, 8'h00, 0); chk("ctrl", q, 0);
      wb(0, 8'h18, 0); chk("unmapped", q, 0);
      op(1, 1, 8'hE0, 0, 8'h02);
      wb(0, 8'h14, 0); chk("bank", q, 2);
      op(1, 1, 8'h10, 1, 8'h5A);
      op(1, 0, 8'h10, 1, 0); chk("bank ea", ea, exp_ea(0, 1, 8'h10, 2, 0));
      chk("bank rd", rd, 8'h5A);
      op(1, 1, 8'hD9, 0, 8'h23);
      op(1, 1, 8'hDA, 0, 8'h01);
      wb(0, 8'h10, 0); chk("ptr2", q, 12'h123);
      wr <= 8'h03;
      op(1, 0, 8'hDB, 0, 0); chk("indirect_plus_working_offset ea", ea, 12'h126);
      op(1, 1, 8'hE1, 0, 8'hD9);
      op(1, 1, 8'hE2, 0, 8'h0F);
      op(1, 1, 8'hE5, 0, 8'h40);
      wb(0, 8'h10, 0); chk("ptr2 wr", q, 12'h140);
      wb(0, 8'h0C, 0); chk("ptr1 nostep", q, 12'hFD9);
      op(1, 1, 8'hE9, 0, 8'hE7);
      op(1, 1, 8'hEA, 0, 8'h0F);
      op(1, 0, 8'hEF, 0, 8'h00); chk("nested rd", rd, 0);
      op(1, 1, 8'hEF, 0, 8'h77);
      wb(0, 8'h04, 0); chk("last nested", q, 32'h00006FE7);
      wb(0, 8'h08, 0); chk("ptr0 nostep", q, 12'hFE7);
      wb(0, 8'h10, 0); chk("nested wr", q, 12'h140);
      op(1, 1, 8'hE1, 0, 8'hE0);
      op(1, 1, 8'hE7, 0, 8'h03);
      wb(0, 8'h14, 0); chk("sfr indirect", q, 3);
      op(0, 0, 8'h05, 0, 0); chk("inherent ea", ea, 0);
      wb(1, 8'h00, 1);
      for (int i = 0; i < 8; i++)
      begin
         f = (i == 0) ? 8'h5F : 8'($urandom % 96);
         d = 8'($urandom);
         op(1, 1, f, 0, d);
         op(1, 0, f, 0, 0); chk("lit ea", ea, exp_ea(1, 0, f, 3, 12'h140));
         chk("lit flag", lit, 1);
         chk("lit rd", rd, d);
      end
      wb(0, 8'h04, 0); chk("last lit", q, {20'h00001, exp_ea(1, 0, f, 3, 12'h140)});
      op(1, 0, 8'h60, 0, 0); chk("f60 ea", ea, exp_ea(1, 0, 8'h60, 3, 12'h140));
      op(1, 0, 8'h05, 1, 0); chk("a1 ea", ea, exp_ea(1, 1, 8'h05, 3, 12'h140));
      op(1, 1, 8'hE9, 0, 8'h20);
      op(1, 1, 8'hEF, 0, 8'h99);
      op(1, 0, 8'hEF, 0, 0); chk("ptr0 rd", rd, 8'h99);
      chk("ptr0 ea", ea, 12'hF20);
      wb(1, 8'h00, 0);
      op(1, 0, 8'h05, 0, 0); chk("std ea", ea, exp_ea(0, 0, 8'h05, 3, 0));
      finish_test;
   end
endmodule
